// ==== hw/eip_ext_irq_select.sv ====
// Purpose: External interrupt pin selection, polarity and port 0 pin claiming
// Assumes: Port 0 pins arrive asynchronously; special-function strobes are synchronous
// Notes: Interrupt inputs only observe pins and never drive them

// Summary of operation
// - Bit 7 sets second interrupt polarity
// - Bit 3 sets first interrupt polarity
// - Bits 6:4 pick second interrupt pin
// - Bits 2:0 pick first interrupt pin
// - Sampling never disturbs pin or routed peripheral
// - Crossbar never routes peripherals to skipped pins
// - Register answers at 0xE4, page F
// - Crystal mode takes pins 2 and 3
// - Other oscillator modes take only pin 3
// - Type bit chooses edge or level sensitivity
// - Edge mode flag clears on vectoring
// - Level mode flag follows active input
module eip_ext_irq_select
  import eip_pkg::*;
#(
  parameter int PORT_WIDTH = EIP_PORT_WIDTH,
  parameter int SEL_WIDTH = EIP_SEL_WIDTH
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] sfr_addr,
  input wire logic [3:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [PORT_WIDTH-1:0] port0_in,
  input wire logic irq0_type,
  input wire logic irq1_type,
  input wire logic [EIP_NUM_IRQ-1:0] irq_vector_ack,
  input wire logic [EIP_NUM_IRQ-1:0] irq_sw_set,
  input wire logic [EIP_NUM_IRQ-1:0] irq_sw_clr,
  output logic irq0_pending,
  output logic irq1_pending,
  output logic external_irq_a,
  output logic external_irq_b,
  input wire logic [PORT_WIDTH-1:0] crossbar_skip_reg,
  input wire logic [PORT_WIDTH-1:0] periph_pin_request,
  output logic [PORT_WIDTH-1:0] crossbar_pin_grant,
  input wire logic ext_osc_enable,
  input wire eip_osc_mode_e ext_osc_control,
  output logic [PORT_WIDTH-1:0] osc_pin_claim,
  output logic osc_pin_a,
  output logic osc_pin_b
);

  // Refuse port widths the three-bit selectors cannot address exactly
  if (PORT_WIDTH != (1 << SEL_WIDTH) || SEL_WIDTH != EIP_SEL_WIDTH)
  begin : g_bad_width
    $error("eip_ext_irq_select: PORT_WIDTH must equal 2**SEL_WIDTH with SEL_WIDTH 3");
  end

  // Complete block state
  typedef struct packed
  {
    logic [7:0] cfg; // Configuration register
    logic [PORT_WIDTH-1:0] sync1; // First synchroniser stage
    logic [PORT_WIDTH-1:0] sync2; // Second synchroniser stage
    logic [EIP_NUM_IRQ-1:0] active; // Polarity corrected selected pins
    logic [7:0] rdata; // Read answer
    logic [PORT_WIDTH-1:0] grant; // Crossbar pin grants
    logic [PORT_WIDTH-1:0] claim; // Oscillator pin claims
  } eip_top_s;

  eip_top_s st; // Registered state
  eip_top_s next_st; // Next state
  logic cfg_hit; // Access targets configuration register
  logic [EIP_NUM_IRQ-1:0] pend; // Pending flags from channels
  logic [EIP_NUM_IRQ-1:0] type_bits; // Edge/level selects

  // Pick a synchronised pin and apply polarity; 1 means active
  function automatic logic pin_active(
    input logic [PORT_WIDTH-1:0] pins,
    input logic [SEL_WIDTH-1:0] sel,
    input logic pol
  );
    logic lvl;
    lvl = pins[sel];
    pin_active = pol ? lvl : ~lvl;
  endfunction : pin_active

  // Oscillator pins taken for a given mode
  function automatic logic [PORT_WIDTH-1:0] osc_pins(
    input logic en,
    input eip_osc_mode_e mode
  );
    logic [PORT_WIDTH-1:0] m;
    m = '0;
    if (en)
    begin
      unique case (mode)
        EIP_OSC_CRYSTAL:
        begin
          // Crystal or resonator across both pins
          m[EIP_OSC_PIN_A_IDX] = 1'b1;
          m[EIP_OSC_PIN_B_IDX] = 1'b1;
        end
        EIP_OSC_CAPACITOR, EIP_OSC_RC, EIP_OSC_CMOS:
        begin
          // Single input connection only
          m[EIP_OSC_PIN_B_IDX] = 1'b1;
        end
      endcase
    end
    osc_pins = m;
  endfunction : osc_pins

  // Address and page decode
  assign cfg_hit = (sfr_addr == EIP_CFG_ADDR) && (sfr_page == EIP_CFG_PAGE);
  assign type_bits = {irq1_type, irq0_type};

  // Next state of the whole block
  always_comb
  begin
    next_st = st;
    // Register write
    if (sfr_wr && cfg_hit)
    begin
      next_st.cfg = sfr_wdata;
    end
    // Registered read answer, zero when not addressed
    if (sfr_rd && cfg_hit)
    begin
      next_st.rdata = st.cfg;
    end
    else
    begin
      next_st.rdata = EIP_READ_ZERO;
    end
    // Two-stage synchroniser on all port 0 pins
    next_st.sync1 = port0_in;
    next_st.sync2 = st.sync1;
    // Selection and polarity on synchronised pins only; pins are read, never driven
    next_st.active[0] = pin_active(st.sync2, st.cfg[EIP_IRQ0_SEL_LSB +: SEL_WIDTH],
                                   st.cfg[EIP_IRQ0_POL_BIT]);
    next_st.active[1] = pin_active(st.sync2, st.cfg[EIP_IRQ1_SEL_LSB +: SEL_WIDTH],
                                   st.cfg[EIP_IRQ1_POL_BIT]);
    // Oscillator pin claims
    next_st.claim = osc_pins(ext_osc_enable, ext_osc_control);
    // Crossbar grants exclude skipped and oscillator pins
    next_st.grant = periph_pin_request & ~crossbar_skip_reg & ~next_st.claim;
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      st <= '0;
      st.cfg <= EIP_CFG_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // One pending-flag channel per external interrupt
  for (genvar i = 0; i < EIP_NUM_IRQ; i++)
  begin : g_chan
    eip_irq_channel u_chan
    (
      .core_clk(core_clk),
      .srst(srst),
      .active(st.active[i]),
      .edge_mode(type_bits[i]),
      .vector_ack(irq_vector_ack[i]),
      .sw_set(irq_sw_set[i]),
      .sw_clr(irq_sw_clr[i]),
      .pending(pend[i])
    );
  end

  // Outputs, all from flip-flops
  assign sfr_rdata = st.rdata;
  assign irq0_pending = pend[0];
  assign irq1_pending = pend[1];
  assign external_irq_a = st.active[0];
  assign external_irq_b = st.active[1];
  assign crossbar_pin_grant = st.grant;
  assign osc_pin_claim = st.claim;
  assign osc_pin_a = st.claim[EIP_OSC_PIN_A_IDX];
  assign osc_pin_b = st.claim[EIP_OSC_PIN_B_IDX];

endmodule : eip_ext_irq_select

// ==== hw/eip_pkg.sv ====
// Purpose: Shared constants and types for the external interrupt pin select block
// Assumes: Special-function register space with 8-bit address and 4-bit page select
// Notes: Bit positions and pin indices of port 0 are given here once

package eip_pkg;

  // Special-function address and page of the configuration register
  localparam logic [7:0] EIP_CFG_ADDR = 8'hE4;
  localparam logic [3:0] EIP_CFG_PAGE = 4'hF;

  // Reset value of the configuration register
  localparam logic [7:0] EIP_CFG_RESET = 8'h01;

  // Field positions inside the configuration register
  localparam int EIP_IRQ1_POL_BIT = 7;
  localparam int EIP_IRQ1_SEL_LSB = 4;
  localparam int EIP_IRQ0_POL_BIT = 3;
  localparam int EIP_IRQ0_SEL_LSB = 0;
  localparam int EIP_SEL_WIDTH = 3;

  // Port 0 width and the pins the oscillator occupies
  localparam int EIP_PORT_WIDTH = 8;
  localparam int EIP_OSC_PIN_A_IDX = 2;
  localparam int EIP_OSC_PIN_B_IDX = 3;

  // Number of external interrupt channels
  localparam int EIP_NUM_IRQ = 2;

  // Empty read answer
  localparam logic [7:0] EIP_READ_ZERO = 8'h00;

  // External oscillator configuration types
  typedef enum logic [1:0]
  {
    EIP_OSC_CRYSTAL,
    EIP_OSC_CAPACITOR,
    EIP_OSC_RC,
    EIP_OSC_CMOS
  } eip_osc_mode_e;

endpackage : eip_pkg

// ==== hw/eip_irq_channel.sv ====
// Purpose: Pending flag of one external interrupt, edge or level sensitive
// Assumes: active input is already synchronised and polarity corrected
// Notes: In edge mode a new edge wins over a clear in the same cycle

module eip_irq_channel
  import eip_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic active,
  input wire logic edge_mode,
  input wire logic vector_ack,
  input wire logic sw_set,
  input wire logic sw_clr,
  output logic pending
);

  // Channel state
  typedef struct packed
  {
    logic pending; // Interrupt pending flag
    logic prev; // Active level one cycle ago
  } eip_chan_s;

  eip_chan_s st; // Registered state
  eip_chan_s next_st; // Next state

  // Flag update for both sensitivity modes
  always_comb
  begin
    next_st = st;
    next_st.prev = active;
    if (edge_mode)
    begin
      // Edge mode: set on inactive-to-active, cleared on vectoring
      if ((active && !st.prev) || sw_set)
      begin
        next_st.pending = 1'b1;
      end
      else if (vector_ack || sw_clr)
      begin
        next_st.pending = 1'b0;
      end
    end
    else
    begin
      // Level mode: flag simply follows the active input
      next_st.pending = active;
    end
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pending = st.pending;

endmodule : eip_irq_channel

// ==== testbench/eip_ext_irq_select_asserts.sv ====
// Purpose: Checker for the external interrupt pin select block
// Assumes: Bound onto eip_ext_irq_select
// Notes: Shadows the config register from write strobes
module eip_sel_asserts
  import eip_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] sfr_addr,
  input wire logic [3:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic [7:0] port0_in,
  input wire logic irq0_type,
  input wire logic [1:0] irq_vector_ack,
  input wire logic [1:0] irq_sw_set,
  input wire logic irq0_pending,
  input wire logic external_irq_a,
  input wire logic external_irq_b,
  input wire logic [7:0] crossbar_skip_reg,
  input wire logic [7:0] crossbar_pin_grant,
  input wire logic ext_osc_enable,
  input wire eip_osc_mode_e ext_osc_control,
  input wire logic [7:0] osc_pin_claim
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [7:0] cfg; // Shadow of the config
  logic [2:0] up; // Cycles since reset
  logic hit; // Register selected
  assign hit = sfr_addr == EIP_CFG_ADDR && sfr_page == EIP_CFG_PAGE;
  // Shadow and warm-up counter
  always_ff @(posedge core_clk)
  begin
    if (srst)
      cfg <= EIP_CFG_RESET;
    else if (hit && sfr_wr)
      cfg <= sfr_wdata;
    up <= srst ? 3'h0 : (up[2] ? up : up + 3'h1);
  end
  a_read_hit: assert property (hit && sfr_rd |=> sfr_rdata == $past(cfg)) else $error("bad read");
  a_read_miss: assert property (!(hit && sfr_rd) |=> sfr_rdata == 8'h00) else $error("stray read");
  a_pin_a: assert property (up[2] && cfg == $past(cfg, 3) |->
    external_irq_a == ($past(port0_in[cfg[2:0]], 3) ~^ cfg[3])) else $error("irq a wrong");
  a_pin_b: assert property (up[2] && cfg == $past(cfg, 3) |->
    external_irq_b == ($past(port0_in[cfg[6:4]], 3) ~^ cfg[7])) else $error("irq b wrong");
  a_level_follow: assert property (up[2] && !irq0_type |=> irq0_pending == $past(external_irq_a))
    else $error("level flag wrong");
  a_ack_clear: assert property (irq0_type && irq_vector_ack[0] && !irq_sw_set[0] && $stable(external_irq_a)
    |=> !irq0_pending) else $error("ack kept flag");
  a_skip_grant: assert property ((crossbar_pin_grant & $past(crossbar_skip_reg)) == 8'h00)
    else $error("skipped pin granted");
  a_osc_claim: assert property ($past(!srst && ext_osc_enable) |-> osc_pin_claim ==
    ($past(ext_osc_control) == EIP_OSC_CRYSTAL ? 8'h0C : 8'h08)) else $error("bad claim");
  c_write: cover property (hit && sfr_wr);
  c_edge: cover property (irq0_type && $rose(irq0_pending));
  c_crystal: cover property (osc_pin_claim == 8'h0C);
endmodule : eip_sel_asserts
bind eip_ext_irq_select eip_sel_asserts i_chk (.*);

// ==== testbench/eip_pin_src.sv ====
// Purpose: Interrupt sources on port 0 pins
// Assumes: Bench sets the wanted pin levels
// Notes: Levels move only at the falling edge
module eip_pin_src
(
  input wire logic core_clk,
  input wire logic [7:0] want,
  output logic [7:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins = 8'h00;
  // Each source holds its level until told otherwise
  always @(negedge core_clk)
    pins <= want;
endmodule : eip_pin_src

// ==== testbench/tb.sv ====
// Purpose: Bench for the external interrupt pin select block
// Assumes: Inputs move at the falling edge
// Notes: Waits follow the fixed latencies
module tb;
  import eip_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, srst = 1, sfr_wr = 0, sfr_rd = 0, irq0_type = 0, irq1_type = 0, ext_osc_enable = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, crossbar_skip_reg = 8'h00, periph_pin_request = 8'h00;
  logic [7:0] want = 8'h00, e, sfr_rdata, port0_in, crossbar_pin_grant, osc_pin_claim;
  logic [3:0] sfr_page = 4'hF;
  logic [1:0] irq_vector_ack = 2'h0, irq_sw_set = 2'h0, irq_sw_clr = 2'h0;
  logic irq0_pending, irq1_pending, external_irq_a, external_irq_b, osc_pin_a, osc_pin_b;
  eip_osc_mode_e ext_osc_control = EIP_OSC_CRYSTAL;
  int errors = 0, num_checks = 0;
  eip_ext_irq_select i_dut (.*);
  eip_pin_src i_src (.core_clk(core_clk), .want(want), .pins(port0_in));
  initial forever #12.5 core_clk = ~core_clk;
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Register write, or read with compare
  task automatic acc(input logic w, input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {sfr_page, sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {pg, a, d, w, !w};
    @(negedge core_clk);
    {sfr_wr, sfr_rd} = 2'h0;
    if (!w)
      chk(sfr_rdata, d);
  endtask : acc
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick
  // One-cycle ack, set and clear pulses
  task automatic pulse(input logic [1:0] a, input logic [1:0] s, input logic [1:0] c);
    @(negedge core_clk);
    {irq_vector_ack, irq_sw_set, irq_sw_clr} = {a, s, c};
    @(negedge core_clk);
    {irq_vector_ack, irq_sw_set, irq_sw_clr} = 6'h00;
    tick(1);
  endtask : pulse
  task automatic conclude;
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  // Watchdog
  initial
  begin
    #200us;
    errors++;
    conclude();
  end
  initial
  begin
    tick(6);
    srst = 0;
    acc(0, 4'hF, 8'hE4, 8'h01);
    acc(1, 4'h0, 8'hE4, 8'h5A);
    acc(1, 4'hF, 8'hE5, 8'h5A);
    acc(0, 4'h0, 8'hE4, 8'h00);
    acc(0, 4'hF, 8'hE4, 8'h01);
    // Every pin on both channels, second channel active high, first active low
    for (int n = 0; n < 8; n++)
    begin
      e = {1'b1, 3'(n), 1'b0, 3'(7 - n)};
      acc(1, 4'hF, 8'hE4, e);
      acc(0, 4'hF, 8'hE4, e);
      want = 8'h01 << n;
      tick(6);
      chk({6'h00, external_irq_b, external_irq_a}, 8'h03);
      want = ~want;
      tick(6);
      chk({6'h00, external_irq_b, external_irq_a}, 8'h00);
    end
    // Edge mode on pin 0, active high
    acc(1, 4'hF, 8'hE4, 8'h08);
    want = 8'h00;
    irq0_type = 1;
    tick(6);
    pulse(2'h1, 2'h0, 2'h0);
    want = 8'h01;
    tick(6);
    want = 8'h00;
    tick(6);
    chk({7'h00, irq0_pending}, 8'h01);
    pulse(2'h1, 2'h0, 2'h0);
    chk({7'h00, irq0_pending}, 8'h00);
    pulse(2'h0, 2'h1, 2'h0);
    chk({7'h00, irq0_pending}, 8'h01);
    pulse(2'h0, 2'h0, 2'h1);
    chk({7'h00, irq0_pending}, 8'h00);
    // Level mode follows the pin
    irq0_type = 0;
    tick(2);
    chk({7'h00, irq0_pending}, 8'h00);
    want = 8'h01;
    tick(6);
    pulse(2'h1, 2'h0, 2'h1);
    chk({7'h00, irq0_pending}, 8'h01);
    // Edge mode on the second channel, pin 5 active high
    want = 8'h00;
    acc(1, 4'hF, 8'hE4, 8'hD8);
    irq1_type = 1;
    tick(6);
    pulse(2'h2, 2'h0, 2'h0);
    chk({7'h00, irq1_pending}, 8'h00);
    want = 8'h20;
    tick(6);
    want = 8'h00;
    tick(6);
    chk({7'h00, irq1_pending}, 8'h01);
    pulse(2'h2, 2'h0, 2'h0);
    chk({7'h00, irq1_pending}, 8'h00);
    // Set and clear in one cycle: set wins
    pulse(2'h0, 2'h2, 2'h2);
    chk({7'h00, irq1_pending}, 8'h01);
    pulse(2'h2, 2'h0, 2'h0);
    chk({7'h00, irq1_pending}, 8'h00);
    // Oscillator modes, then disabled; pins stay bench inputs only
    periph_pin_request = 8'hFF;
    crossbar_skip_reg = 8'h01;
    for (int m = 0; m < 5; m++)
    begin
      ext_osc_enable = m < 4;
      ext_osc_control = eip_osc_mode_e'(m[1:0]);
      e = m == 0 ? 8'h0C : (m < 4 ? 8'h08 : 8'h00);
      tick(3);
      chk(osc_pin_claim, e);
      chk({6'h00, osc_pin_b, osc_pin_a}, {6'h00, e[3], e[2]});
      chk(crossbar_pin_grant, 8'hFE & ~e);
    end
    conclude();
  end
endmodule : tb
